// File: dv/icc_src.sv
// Partner model: external digital sources (switches, encoder) on the twelve input channels.
// Assumes: bench clock; every pin change lands 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module icc_src (
  input wire logic i_clk_sys,
  output logic [11:0] o_pins
);
  logic [1:0] ph;
  initial begin
    o_pins = 12'h000;
    ph = 2'h0;
  end
  // Set all pins, then hold them for a number of cycles
  task automatic drive(input logic [11:0] v, input int hold);
    @(posedge i_clk_sys);
    #1;
    o_pins = v;
    repeat (hold) @(posedge i_clk_sys);
    #1;
  endtask
  // One high pulse on a channel, prompt or slow by hold
  task automatic pulse(input int ch, input int hold);
    drive(o_pins | (12'h001 << ch), hold);
    drive(o_pins & ~(12'h001 << ch), hold);
  endtask
  // Gray steps on A (pin 0) and B (pin 1), A leading when up
  task automatic quad(input logic up, input int n);
    repeat (n) begin
      ph = up ? ph + 2'h1 : ph - 2'h1;
      drive({o_pins[11:2], ph[1], ph[1] ^ ph[0]}, 3);
    end
  endtask
endmodule
`default_nettype wire

// File: dv/tb_input_counter_capture_block.sv
// Self-checking bench for the input counter capture block.
// Assumes: icc_pkg and icc_top compiled first; icc_src drives the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_input_counter_capture_block;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [3:0] i_read_channel = 4'h0, i_up_channel = 4'h3, i_down_channel = 4'h4;
  logic [3:0] i_quad_a_channel = 4'h0, i_quad_b_channel = 4'h1, i_quad_index_channel = 4'h2;
  logic [3:0] i_primary_channel = 4'h5, i_second_channel = 4'h6;
  logic [1:0] i_up_edge = 2'h0, i_down_edge = 2'h0, i_primary_edge = 2'h0, i_second_edge = 2'h0;
  logic [11:0] i_irq_enable = 12'h000, i_irq_clear = 12'h000;
  logic [23:0] i_irq_edge = 24'h000000;
  logic [15:0] i_match_target = 16'h0000, i_limit_value = 16'h0000;
  logic i_match_load = 1'b0, i_quad_index_en = 1'b0, i_quad_index_level = 1'b0, i_synch = 1'b0;
  logic i_same_channel = 1'b0, i_active_level_select = 1'b0, i_use_prescale = 1'b0;
  logic i_prescale_tick = 1'b0, i_capture_setup = 1'b0, i_keep_limit_option = 1'b0;
  logic i_limit_write = 1'b0, i_counter_clear = 1'b0;
  icc_pkg::function_t i_function = icc_pkg::fn_general;
  icc_pkg::count_mode_t i_count_mode = icc_pkg::mode_count_up;
  icc_pkg::capture_mode_t i_capture_mode = icc_pkg::capture_free_run;
  wire logic [11:0] i_input_channels;
  logic o_read_level, o_running;
  logic [7:0] o_bank0, o_bank1;
  logic [11:0] o_irq_flags;
  logic [15:0] o_count, o_begin_count, o_end_count, o_limit, o_match0, o_match1;
  logic [11:0] lv = 12'ha5c;
  int n_errors = 0;
  int total_checks = 0;

  always #20 i_clk_sys = ~i_clk_sys;

  icc_src icc_src_i (.i_clk_sys, .o_pins(i_input_channels));
  icc_top icc_top_i (.i_clk_sys, .i_rst, .i_ce, .i_input_channels, .i_read_channel,
    .o_read_level, .o_bank0, .o_bank1, .i_irq_enable, .i_irq_edge, .i_irq_clear,
    .o_irq_flags, .i_function, .i_count_mode, .i_up_channel, .i_up_edge, .i_down_channel,
    .i_down_edge, .i_match_target, .i_match_load, .i_quad_a_channel, .i_quad_b_channel,
    .i_quad_index_en, .i_quad_index_channel, .i_quad_index_level, .i_synch, .i_capture_mode,
    .i_primary_channel, .i_primary_edge, .i_same_channel, .i_second_channel, .i_second_edge,
    .i_active_level_select, .i_use_prescale, .i_prescale_tick, .i_capture_setup,
    .i_keep_limit_option, .i_limit_write, .i_limit_value, .i_counter_clear, .o_count,
    .o_begin_count, .o_end_count, .o_limit, .o_match0, .o_match1, .o_running);

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic clr();
    i_counter_clear = 1'b1;
    step(1);
    i_counter_clear = 1'b0;
    step(1);
  endtask
  task automatic setup();
    i_capture_setup = 1'b1;
    step(1);
    i_capture_setup = 1'b0;
    clr();
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      i_prescale_tick = 1'b1;
      step(1);
      i_prescale_tick = 1'b0;
      step(1);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge i_clk_sys);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    step(12);
    i_rst = 1'b0;
    step(1);
    chk(o_limit, 16'hffff, "limit reset");
    chk(o_match1, 16'hffff, "match1 reset");
    chk(o_count, 16'h0000, "count reset");
    icc_src_i.drive(lv, 5);
    chk({8'h00, o_bank0}, 16'h005c, "bank0");
    chk({8'h00, o_bank1}, 16'h000a, "bank1");
    for (int c = 0; c < 12; c++) begin
      i_read_channel = c[3:0];
      step(1);
      chk({15'h0, o_read_level}, {15'h0, lv[c]}, "read level");
    end
    $display("levels done");
    icc_src_i.drive(12'h000, 5);
    i_irq_enable = 12'h007;
    i_irq_edge = {18'h0, icc_pkg::EDGE_EITHER, icc_pkg::EDGE_FALLING, icc_pkg::EDGE_RISING};
    icc_src_i.drive(12'h00f, 5);
    chk({4'h0, o_irq_flags}, 16'h0005, "irq on rise");
    i_irq_clear = 12'hfff;
    step(2);
    i_irq_clear = 12'h000;
    icc_src_i.drive(12'h000, 5);
    chk({4'h0, o_irq_flags}, 16'h0006, "irq on fall");
    $display("interrupts done");
    i_function = icc_pkg::fn_counter;
    for (int e = 0; e < 3; e++) begin
      i_up_edge = e[1:0];
      clr();
      icc_src_i.pulse(3, 3);
      step(4);
      chk(o_count, (e == 2) ? 16'h0002 : 16'h0001, "edge count");
    end
    i_up_edge = icc_pkg::EDGE_RISING;
    i_count_mode = icc_pkg::mode_count_up_down;
    clr();
    icc_src_i.pulse(3, 3);
    icc_src_i.pulse(3, 3);
    icc_src_i.pulse(4, 3);
    step(4);
    chk(o_count, 16'h0001, "up down");
    icc_src_i.pulse(4, 3);
    icc_src_i.pulse(4, 3);
    step(4);
    chk(o_count, 16'hffff, "down wrap");
    clr();
    chk(o_count, 16'h0000, "clear");
    i_down_channel = 4'h3;
    icc_src_i.pulse(3, 3);
    step(4);
    chk(o_count, 16'h0001, "same pin down ignored");
    i_down_channel = 4'h4;
    i_count_mode = icc_pkg::mode_stop_on_match;
    i_match_target = 16'h0002;
    i_match_load = 1'b1;
    step(1);
    i_match_load = 1'b0;
    step(1);
    chk(o_match0, 16'h0002, "match0");
    chk(o_match1, 16'hffff, "match1");
    clr();
    repeat (4) icc_src_i.pulse(3, 3);
    step(4);
    chk(o_count, 16'h0002, "stop on match");
    i_count_mode = icc_pkg::mode_count_up;
    i_limit_value = 16'h0003;
    i_limit_write = 1'b1;
    step(1);
    i_limit_write = 1'b0;
    clr();
    chk(o_limit, 16'h0003, "limit write");
    repeat (4) icc_src_i.pulse(3, 3);
    step(4);
    chk(o_count, 16'h0000, "up wrap");
    i_keep_limit_option = 1'b1;
    setup();
    chk(o_limit, 16'h0003, "limit kept");
    i_keep_limit_option = 1'b0;
    setup();
    chk(o_limit, 16'hffff, "limit all ones");
    $display("counter done");
    i_function = icc_pkg::fn_decoder;
    clr();
    icc_src_i.quad(1'b1, 4);
    step(4);
    chk(o_count, 16'h0004, "quad fwd");
    icc_src_i.quad(1'b0, 4);
    step(4);
    chk(o_count, 16'h0000, "quad back");
    i_quad_index_en = 1'b1;
    i_quad_index_level = 1'b1;
    icc_src_i.quad(1'b1, 2);
    chk(o_count, 16'h0002, "quad before index");
    icc_src_i.pulse(2, 3);
    step(4);
    chk(o_count, 16'h0000, "index clear");
    i_quad_index_en = 1'b0;
    icc_src_i.quad(1'b1, 2);
    i_synch = 1'b1;
    step(2);
    i_synch = 1'b0;
    step(1);
    chk(o_count, 16'h0000, "synch clear");
    $display("decoder done");
    i_function = icc_pkg::fn_capture;
    i_use_prescale = 1'b1;
    clr();
    ticks(5);
    chk(o_count, 16'h0005, "free run ticks");
    i_ce = 1'b0;
    ticks(2);
    i_ce = 1'b1;
    chk(o_count, 16'h0005, "frozen by enable");
    i_use_prescale = 1'b0;
    clr();
    step(3);
    chk(o_count, 16'h0004, "main clock run");
    i_use_prescale = 1'b1;
    i_capture_mode = icc_pkg::capture_start_stop;
    setup();
    icc_src_i.drive(12'h020, 5);
    chk({15'h0, o_running}, 16'h0001, "running");
    ticks(3);
    icc_src_i.drive(12'h060, 5);
    chk(o_begin_count, 16'h0000, "begin");
    chk(o_end_count, 16'h0003, "end");
    chk({15'h0, o_running}, 16'h0000, "stopped");
    icc_src_i.drive(12'h000, 5);
    setup();
    icc_src_i.drive(12'h060, 5);
    chk(o_begin_count, 16'h0000, "early end begin rise");
    chk(o_end_count, 16'h0001, "early end end");
    i_primary_edge = icc_pkg::EDGE_FALLING;
    i_second_edge = icc_pkg::EDGE_FALLING;
    setup();
    icc_src_i.drive(12'h000, 5);
    chk(o_begin_count, 16'h0001, "early end begin fall");
    chk(o_end_count, 16'h0001, "early end end fall");
    i_capture_mode = icc_pkg::capture_while_active;
    icc_src_i.drive(12'h020, 5);
    chk({15'h0, o_running}, 16'h0001, "active high");
    icc_src_i.drive(12'h000, 5);
    chk({15'h0, o_running}, 16'h0000, "inactive");
    i_active_level_select = 1'b1;
    step(4);
    chk({15'h0, o_running}, 16'h0001, "active low");
    i_active_level_select = 1'b0;
    i_primary_edge = icc_pkg::EDGE_RISING;
    i_capture_mode = icc_pkg::capture_until_stop;
    setup();
    icc_src_i.drive(12'h020, 5);
    chk({15'h0, o_running}, 16'h0000, "until end stopped");
    icc_src_i.drive(12'h060, 5);
    icc_src_i.drive(12'h020, 5);
    chk({15'h0, o_running}, 16'h0001, "until begin runs");
    icc_src_i.drive(12'h000, 5);
    icc_src_i.drive(12'h020, 5);
    chk({15'h0, o_running}, 16'h0000, "until end stops");
    $display("capture done");
    complete_run();
  end
endmodule
`default_nettype wire

// File: hdl/icc_edge_if.sv
// Interface: synchronised inputs and per-channel edge pulses.
// Assumes: driven by icc_sync_edge, read by the top module.
`timescale 1ns/1ps
`default_nettype none
interface icc_edge_if #(parameter int N = 12);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// File: hdl/icc_pkg.sv
// Package: shared constants and enums for the input counter capture block.
// Assumes: nothing beyond a SystemVerilog compiler.
package icc_pkg;
  localparam int NUM_CH = 12;
  localparam int CH_W = 4;
  localparam int CNT_W = 16;
  localparam int BANK_W = 8;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_DEFAULT = 16'hffff;
  localparam logic [15:0] MATCH_MAX = 16'hffff;
  localparam logic [3:0] BANK1_LO = 4'h8;
  localparam int BANK1_BITS = 4;
  localparam int NUM_MATCH = 2;
  // Edge selects: 0 rising, 1 falling, 2 either
  localparam logic [1:0] EDGE_RISING = 2'h0;
  localparam logic [1:0] EDGE_FALLING = 2'h1;
  localparam logic [1:0] EDGE_EITHER = 2'h2;
  typedef enum logic [1:0] {
    mode_count_up, mode_count_up_down, mode_stop_on_match
  } count_mode_t;
  typedef enum logic [1:0] {
    capture_free_run, capture_start_stop, capture_until_stop, capture_while_active
  } capture_mode_t;
  typedef enum logic [1:0] {
    fn_general, fn_counter, fn_decoder, fn_capture
  } function_t;
endpackage

// File: hdl/icc_quad.sv
// Quadrature decoder core: A/B step and direction; index and synch clear are done in the top module.
// Assumes: inputs already synchronised, edges one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module icc_quad (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_a,
  input wire logic i_b,
  input wire logic i_a_edge,
  input wire logic i_b_edge,
  output logic o_up,
  output logic o_down
);
  // Direction from which phase moved relative to the other
  logic step;
  assign step = i_ce & (i_a_edge ^ i_b_edge);
  assign o_up = step & ((i_a_edge & (i_a ^ i_b)) | (i_b_edge & ~(i_a ^ i_b)));
  assign o_down = step & ~o_up;
  up_down_excl_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(o_up && o_down)) else $error("quad up and down together");
endmodule
`default_nettype wire

// File: hdl/icc_sync_edge.sv
// Synchroniser and edge detector for all input channels.
// Assumes: one clock, asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module icc_sync_edge #(parameter int N = 12) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [N-1:0] i_pins,
  icc_edge_if.src edges
);
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;
  // Two flops then a history flop
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else if (i_ce) begin
      meta_r <= i_pins;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign edges.level = sync_r;
  assign edges.rise = sync_r & ~prev_r & {N{i_ce}};
  assign edges.fall = ~sync_r & prev_r & {N{i_ce}};
  one_rise_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    edges.rise[0] |=> !edges.rise[0]) else $error("rise pulse too long");
endmodule
`default_nettype wire

// File: hdl/icc_top.sv
// Input counter capture block: level reads, edge events, counter, decoder, capture.
// Assumes: inputs synchronous to i_clk_sys; configuration held stable by software.
//
// Function
// - Twelve channels read as bank 0 (ch 0-7) and bank 1 (ch 8-11).
// - Single channel read returns its level, 0 low, 1 high.
// - Interrupt-enabled channels flag rising, falling or either edge.
// - Quadrature decoder takes A and B from chosen channels, optional index.
// - Synch signal still clears the decoder count.
// - Counter steps once per selected edge, edge per direction selectable.
// - Up/down mode uses one up pin and one down pin.
// - Match mode counts up and stops on any match.
// - Match target held in one match register, others set to maximum.
// - Capture counts main or prescaled clock, gated by the capture mode.
// - Begin and end events latch the count into readable registers.
// - Begin and end may come from two channels of the same block.
// - Free-run mode and start-on-begin, stop-on-end mode.
// - Mode counting only while begin signal is at active level.
// - Count-until-end mode, primary channel selects the end event.
// - End before begin: start and stop at begin, end 1, begin 0 or 1.
// - Begin event edge selectable rising, falling or either.
// - Active level selectable high or low in active-level mode.
// - Software clear forces the counter to its reset value in any cycle with i_ce high.
// - Capture setup loads limit with all ones unless keep limit chosen.
`timescale 1ns/1ps
`default_nettype none
module icc_top #(
  parameter int NUM_CH = icc_pkg::NUM_CH,
  parameter int CNT_W = icc_pkg::CNT_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [NUM_CH-1:0] i_input_channels,
  input wire logic [3:0] i_read_channel,
  output logic o_read_level,
  output logic [7:0] o_bank0,
  output logic [7:0] o_bank1,
  input wire logic [NUM_CH-1:0] i_irq_enable,
  input wire logic [2*NUM_CH-1:0] i_irq_edge,
  input wire logic [NUM_CH-1:0] i_irq_clear,
  output logic [NUM_CH-1:0] o_irq_flags,
  input wire icc_pkg::function_t i_function,
  input wire icc_pkg::count_mode_t i_count_mode,
  input wire logic [3:0] i_up_channel,
  input wire logic [1:0] i_up_edge,
  input wire logic [3:0] i_down_channel,
  input wire logic [1:0] i_down_edge,
  input wire logic [CNT_W-1:0] i_match_target,
  input wire logic i_match_load,
  input wire logic [3:0] i_quad_a_channel,
  input wire logic [3:0] i_quad_b_channel,
  input wire logic i_quad_index_en,
  input wire logic [3:0] i_quad_index_channel,
  input wire logic i_quad_index_level,
  input wire logic i_synch,
  input wire icc_pkg::capture_mode_t i_capture_mode,
  input wire logic [3:0] i_primary_channel,
  input wire logic [1:0] i_primary_edge,
  input wire logic i_same_channel,
  input wire logic [3:0] i_second_channel,
  input wire logic [1:0] i_second_edge,
  input wire logic i_active_level_select,
  input wire logic i_use_prescale,
  input wire logic i_prescale_tick,
  input wire logic i_capture_setup,
  input wire logic i_keep_limit_option,
  input wire logic i_limit_write,
  input wire logic [CNT_W-1:0] i_limit_value,
  input wire logic i_counter_clear,
  output logic [CNT_W-1:0] o_count,
  output logic [CNT_W-1:0] o_begin_count,
  output logic [CNT_W-1:0] o_end_count,
  output logic [CNT_W-1:0] o_limit,
  output logic [CNT_W-1:0] o_match0,
  output logic [CNT_W-1:0] o_match1,
  output logic o_running
);
  icc_edge_if #(.N(NUM_CH)) edges ();
  icc_sync_edge #(.N(NUM_CH)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_pins(i_input_channels),
    .edges(edges)
  );

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel == icc_pkg::EDGE_RISING) ? r :
               (sel == icc_pkg::EDGE_FALLING) ? f : (r | f);
  endfunction

  // Level reads
  assign o_read_level = edges.level[i_read_channel];
  assign o_bank0 = edges.level[7:0];
  assign o_bank1 = {4'h0, edges.level[NUM_CH-1:8]};

  // Interrupt flags
  logic [NUM_CH-1:0] irq_r;
  logic [NUM_CH-1:0] irq_set;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_irq
      assign irq_set[g] = i_irq_enable[g] &
        edge_hit(i_irq_edge[2*g+:2], edges.rise[g], edges.fall[g]);
    end
  endgenerate
  logic [NUM_CH-1:0] irq_nxt;
  assign irq_nxt = (irq_r & ~i_irq_clear) | irq_set;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_r <= '0;
    end else if (i_ce) begin
      irq_r <= irq_nxt;
    end
  end
  assign o_irq_flags = irq_r;

  // Counter events
  logic up_ev;
  logic down_ev;
  assign up_ev = edge_hit(i_up_edge, edges.rise[i_up_channel], edges.fall[i_up_channel]);
  assign down_ev = (i_count_mode == icc_pkg::mode_count_up_down) &&
    (i_down_channel != i_up_channel) &&
    edge_hit(i_down_edge, edges.rise[i_down_channel], edges.fall[i_down_channel]);

  // Quadrature decode
  logic q_up;
  logic q_down;
  icc_quad u_quad (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_a(edges.level[i_quad_a_channel]),
    .i_b(edges.level[i_quad_b_channel]),
    .i_a_edge(edges.rise[i_quad_a_channel] | edges.fall[i_quad_a_channel]),
    .i_b_edge(edges.rise[i_quad_b_channel] | edges.fall[i_quad_b_channel]),
    .o_up(q_up),
    .o_down(q_down)
  );
  logic index_hit;
  assign index_hit = i_quad_index_en &&
    (edges.level[i_quad_index_channel] == i_quad_index_level) &&
    (edges.rise[i_quad_index_channel] | edges.fall[i_quad_index_channel]);

  // Match registers
  logic [CNT_W-1:0] match_r [icc_pkg::NUM_MATCH];
  logic match_hit;
  assign match_hit = (o_count == match_r[0]) || (o_count == match_r[1]);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      match_r[0] <= icc_pkg::MATCH_MAX;
      match_r[1] <= icc_pkg::MATCH_MAX;
    end else if (i_ce && i_match_load) begin
      match_r[0] <= i_match_target;
      match_r[1] <= icc_pkg::MATCH_MAX;
    end
  end
  assign o_match0 = match_r[0];
  assign o_match1 = match_r[1];

  // Limit register
  logic [CNT_W-1:0] limit_r;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      limit_r <= icc_pkg::LIMIT_DEFAULT;
    end else if (i_ce) begin
      if (i_capture_setup && !i_keep_limit_option) begin
        limit_r <= icc_pkg::LIMIT_DEFAULT;
      end else if (i_limit_write) begin
        limit_r <= i_limit_value;
      end
    end
  end
  assign o_limit = limit_r;

  // Capture events
  logic [3:0] sec_ch;
  logic [1:0] sec_edge;
  logic prim_ev;
  logic sec_ev;
  logic begin_ev;
  logic end_ev;
  logic active_lvl;
  logic until_mode;
  assign sec_ch = i_same_channel ? i_primary_channel : i_second_channel;
  assign sec_edge = i_same_channel ? i_primary_edge : i_second_edge;
  assign prim_ev = edge_hit(i_primary_edge, edges.rise[i_primary_channel],
    edges.fall[i_primary_channel]);
  assign sec_ev = edge_hit(sec_edge, edges.rise[sec_ch], edges.fall[sec_ch]);
  assign until_mode = (i_capture_mode == icc_pkg::capture_until_stop);
  assign begin_ev = until_mode ? sec_ev : prim_ev;
  assign end_ev = until_mode ? prim_ev : sec_ev;
  assign active_lvl = edges.level[i_primary_channel] ^ i_active_level_select;

  // Capture run state
  logic run_r;
  logic run_nxt;
  logic tick;
  logic is_capture;
  assign is_capture = (i_function == icc_pkg::fn_capture);
  assign tick = i_use_prescale ? i_prescale_tick : 1'b1;
  always_comb begin
    run_nxt = run_r;
    case (i_capture_mode)
      icc_pkg::capture_free_run: run_nxt = 1'b1;
      icc_pkg::capture_start_stop: begin
        if (begin_ev && !run_r) begin
          run_nxt = !end_ev;
        end else if (end_ev) begin
          run_nxt = 1'b0;
        end
      end
      icc_pkg::capture_until_stop: begin
        if (end_ev) begin
          run_nxt = 1'b0;
        end else if (begin_ev) begin
          run_nxt = 1'b1;
        end
      end
      icc_pkg::capture_while_active: run_nxt = active_lvl;
      default: run_nxt = 1'b0;
    endcase
    if (!is_capture || i_capture_setup) begin
      run_nxt = 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      run_r <= 1'b0;
    end else if (i_ce) begin
      run_r <= run_nxt;
    end
  end
  assign o_running = run_r;

  // Counter next value
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] cnt_dec;
  logic do_up;
  logic do_down;
  logic do_clear;
  assign cnt_inc = (cnt_r >= limit_r) ? icc_pkg::CNT_RESET : cnt_r + 16'h0001;
  assign cnt_dec = (cnt_r == icc_pkg::CNT_RESET) ? limit_r : cnt_r - 16'h0001;
  assign do_clear = i_counter_clear || ((i_function == icc_pkg::fn_decoder) &&
    (i_synch || index_hit));
  always_comb begin
    do_up = 1'b0;
    do_down = 1'b0;
    case (i_function)
      icc_pkg::fn_counter: begin
        if (i_count_mode == icc_pkg::mode_stop_on_match) begin
          do_up = up_ev && !match_hit;
        end else begin
          do_up = up_ev && !down_ev;
          do_down = down_ev && !up_ev;
        end
      end
      icc_pkg::fn_decoder: begin
        do_up = q_up;
        do_down = q_down;
      end
      icc_pkg::fn_capture: do_up = run_nxt && tick;
      default: do_up = 1'b0;
    endcase
  end
  assign cnt_nxt = do_clear ? icc_pkg::CNT_RESET :
                   do_up ? cnt_inc :
                   do_down ? cnt_dec : cnt_r;

  // Begin and end captures
  logic [CNT_W-1:0] beg_r;
  logic [CNT_W-1:0] end_r;
  logic capt_beg;
  logic capt_end;
  logic early_end;
  assign capt_beg = is_capture && begin_ev &&
    (i_capture_mode != icc_pkg::capture_start_stop || !run_r);
  assign early_end = (i_capture_mode == icc_pkg::capture_start_stop) && capt_beg && end_ev;
  assign capt_end = is_capture && end_ev && (run_r || early_end);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= icc_pkg::CNT_RESET;
      beg_r <= icc_pkg::CNT_RESET;
      end_r <= icc_pkg::CNT_RESET;
    end else if (i_ce) begin
      cnt_r <= cnt_nxt;
      if (capt_beg) begin
        beg_r <= early_end ? {15'h0000, edges.fall[i_primary_channel]} : cnt_r;
      end
      if (capt_end) begin
        end_r <= early_end ? 16'h0001 : cnt_r;
      end
    end
  end
  assign o_count = cnt_r;
  assign o_begin_count = beg_r;
  assign o_end_count = end_r;

  bank_level_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $past(i_ce) && $past(i_ce, 2) && !$past(i_rst) && !$past(i_rst, 2) |->
    o_bank1[7:4] == 4'h0 && {o_bank1[3:0], o_bank0} == $past(i_input_channels, 2))
    else $error("bank read wrong");
  clear_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_counter_clear |=> o_count == 16'h0000) else $error("clear missed");
  irq_sticky_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && irq_set[0] |=> o_irq_flags[0]) else $error("irq event lost");
  match_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_function == icc_pkg::fn_counter && i_count_mode == icc_pkg::mode_stop_on_match
    && match_hit && !i_counter_clear |=> $stable(o_count)) else $error("match no stop");
  match_load_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_match_load |=> o_match1 == 16'hffff && o_match0 == $past(i_match_target))
    else $error("match load wrong");
  limit_setup_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_capture_setup && !i_keep_limit_option |=> o_limit == 16'hffff)
    else $error("limit not all ones");
  early_end_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && early_end |=> o_end_count == 16'h0001 && o_begin_count <= 16'h0001)
    else $error("early end values");
  wrap_limit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && do_up && !do_clear && cnt_r >= limit_r |=> o_count == 16'h0000)
    else $error("no wrap at limit");
  level_run_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && is_capture && !i_capture_setup && i_capture_mode == icc_pkg::capture_while_active
    |=> o_running == $past(active_lvl)) else $error("active level run");
  read_one_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $past(i_ce) && $past(i_ce, 2) && !$past(i_rst) && !$past(i_rst, 2) &&
    i_read_channel < 4'hc |->
    o_read_level == |($past(i_input_channels, 2) & (12'h001 << i_read_channel)))
    else $error("level read");
endmodule
`default_nettype wire
